// ---- verification/i2c_master_model.sv ----
`timescale 1ns/1ns

module i2c_master_model #(
    parameter int HALF = 112
) (
    // resolved bus lines
    input wire logic sclWire,
    input wire logic sdaWire,
    // open-drain pulls, high pulls the line low
    output logic sclLow,
    output logic sdaLow,
    // bus hung
    output logic stuck
);
    // extra phase time, lets the bench run a slow master
    int extraNs = 0;

    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        stuck = 1'b0;
    end

    // slave may stretch; bounded so a lost release ends the run
    task automatic rise();
        int n;
        n = 0;
        sclLow = 1'b0;
        while (sclWire !== 1'b1 && n < 3000) begin
            #10;
            n++;
        end
        if (n == 3000) stuck = 1'b1;
        #(HALF + extraNs);
    endtask : rise

    task automatic start_cond();
        sdaLow = 1'b1;
        #HALF;
        sclLow = 1'b1;
    endtask : start_cond

    task automatic send_bit(input logic b, output logic seen);
        #5;
        sdaLow = !b;
        #(HALF + extraNs);
        rise();
        seen = sdaWire;
        sclLow = 1'b1;
    endtask : send_bit

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) send_bit(b[i], s);
        send_bit(1'b1, s);
        ack = !s;
    endtask : send_byte

    task automatic stop_cond();
        #5;
        sdaLow = 1'b1;
        #HALF;
        rise();
        sdaLow = 1'b0;
        #HALF;
    endtask : stop_cond
endmodule : i2c_master_model

// ---- verification/test_i2c_slave_ten_bit_rx.sv ----
`timescale 1ns/1ns
`define CHK(g, e) chk(16'(g), 16'(e))

module test_i2c_slave_ten_bit_rx;
    logic clk, reset, slaveAddressWrite, stretchEnable, addressHoldEnable, dataHoldEnable;
    logic startIrqEnable, clockReleaseSet, irqFlagClear, bufferRead;
    logic sclOut, sclOeN, sdaOut, sdaOeN, bufferFullFlag, serialPortIrqFlag, addressRefreshFlag;
    logic startSeen, stopSeen, clockReleaseBit, mSclLow, mSdaLow, stuck, drainOn, ack;
    logic [7:0] slaveAddressData, receiveBuffer, slaveAddressReg, lowAddr;
    logic [7:0] q[$];
    logic [7:0] badHigh[2] = '{8'hf6, 8'hf5};
    wire logic sclWire;
    wire logic sdaWire;
    int err_total = 0;
    int n_compared = 0;
    int seed = 86;
    int rdGap = 0;

    // pull-ups: a line is high unless some party pulls it
    assign sclWire = !(mSclLow || (sclOeN === 1'b0 && sclOut === 1'b0));
    assign sdaWire = !(mSdaLow || (sdaOeN === 1'b0 && sdaOut === 1'b0));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    i2c_slave_ten_bit_rx u_dut (.clk(clk), .reset(reset), .sclClk(sclWire), .sclIn(sclWire), .sclOut(sclOut),
        .sclOeN(sclOeN), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .slaveAddressData(slaveAddressData),
        .slaveAddressWrite(slaveAddressWrite), .stretchEnable(stretchEnable), .addressHoldEnable(addressHoldEnable),
        .dataHoldEnable(dataHoldEnable), .startIrqEnable(startIrqEnable), .clockReleaseSet(clockReleaseSet),
        .irqFlagClear(irqFlagClear), .bufferRead(bufferRead), .receiveBuffer(receiveBuffer),
        .bufferFullFlag(bufferFullFlag), .serialPortIrqFlag(serialPortIrqFlag),
        .addressRefreshFlag(addressRefreshFlag), .startSeen(startSeen), .stopSeen(stopSeen),
        .clockReleaseBit(clockReleaseBit), .slaveAddressReg(slaveAddressReg));

    // phases kept above the 100 ns floor, so the link clock is slower than 200 ns
    i2c_master_model u_master (.sclWire(sclWire), .sdaWire(sdaWire), .sclLow(mSclLow), .sdaLow(mSdaLow),
        .stuck(stuck));

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    // 0 address write, 1 clock release, other irq clear
    task automatic sw(input int which, input logic [7:0] v);
        @(posedge clk);
        case (which)
            0: begin
                slaveAddressData <= v;
                slaveAddressWrite <= 1'b1;
            end
            1: clockReleaseSet <= 1'b1;
            default: irqFlagClear <= 1'b1;
        endcase
        @(posedge clk);
        slaveAddressWrite <= 1'b0;
        clockReleaseSet <= 1'b0;
        irqFlagClear <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : sw

    task automatic xfer(input logic [7:0] b, input logic expAck, input logic expIrq);
        if (expAck) q.push_back(b);
        u_master.send_byte(b, ack);
        repeat (8) @(posedge clk);
        `CHK(ack, expAck);
        `CHK(serialPortIrqFlag, expIrq);
        sw(2, 8'h00);
    endtask : xfer

    // software side drains the buffer against the expected bytes
    always @(posedge clk) begin
        if (reset) begin
            bufferRead <= 1'b0;
        end else if (rdGap != 0) begin
            rdGap <= rdGap - 1;
            bufferRead <= 1'b0;
        end else if (drainOn && bufferFullFlag === 1'b1) begin
            if (q.size() == 0) `CHK(1, 0);
            else `CHK(receiveBuffer, q.pop_front());
            bufferRead <= 1'b1;
            rdGap <= 3;
        end
    end

    always @(posedge stuck) begin
        err_total++;
        close_out();
    end

    initial begin
        #500000;
        err_total++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        {slaveAddressWrite, addressHoldEnable, dataHoldEnable, clockReleaseSet, irqFlagClear} = 5'h00;
        {stretchEnable, startIrqEnable, drainOn, slaveAddressData} = {3'h7, 8'h00};
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK({sclOeN, sdaOeN, clockReleaseBit}, 3'h7);
        `CHK({serialPortIrqFlag, addressRefreshFlag, bufferFullFlag}, 3'h0);
        `CHK(slaveAddressReg, 8'hf0);
        lowAddr = 8'($random(seed));
        sw(0, 8'hf4);
        `CHK(slaveAddressReg, 8'hf4);
        u_master.start_cond();
        `CHK({startSeen, serialPortIrqFlag}, 2'b11);
        sw(2, 8'h00);
        xfer(8'hf4, 1'b1, 1'b1);
        `CHK({addressRefreshFlag, sclOeN}, 2'b10);
        sw(0, lowAddr);
        `CHK({addressRefreshFlag, sclOeN, slaveAddressReg}, {2'b01, lowAddr});
        fork
            xfer(lowAddr, 1'b1, 1'b1);
            begin : ackWrite
                int n;
                for (n = 0; n < 400 && sdaOeN !== 1'b0; n++) @(posedge clk);
                `CHK(n < 400, 1'b1);
                sw(0, 8'h55);
            end
        join
        `CHK({addressRefreshFlag, slaveAddressReg}, {1'b1, lowAddr});
        sw(0, 8'hf4);
        `CHK(addressRefreshFlag, 1'b0);
        for (int i = 0; i < 3; i++) begin
            u_master.extraNs = (i == 1) ? 300 : 0;
            xfer(8'($random(seed)), 1'b1, 1'b1);
            `CHK({clockReleaseBit, sclOeN}, 2'b00);
            sw(1, 8'h00);
            `CHK({clockReleaseBit, sclOeN}, 2'b11);
        end
        u_master.stop_cond();
        `CHK({stopSeen, startSeen, bufferFullFlag}, 3'b100);
        startIrqEnable <= 1'b0;
        u_master.start_cond();
        `CHK({startSeen, stopSeen, serialPortIrqFlag}, 3'b100);
        xfer(8'hf4, 1'b1, 1'b1);
        sw(0, lowAddr);
        xfer(lowAddr ^ 8'h01, 1'b0, 1'b1);
        `CHK({addressRefreshFlag, clockReleaseBit, bufferFullFlag}, 3'b110);
        sw(0, 8'hf4);
        xfer(8'h3c, 1'b0, 1'b0);
        u_master.stop_cond();
        foreach (badHigh[i]) begin
            u_master.start_cond();
            xfer(badHigh[i], 1'b0, 1'b0);
            xfer(8'h5a, 1'b0, 1'b0);
            u_master.stop_cond();
        end
        stretchEnable <= 1'b0;
        addressHoldEnable <= 1'b1;
        u_master.start_cond();
        xfer(8'hf4, 1'b1, 1'b1);
        sw(0, lowAddr);
        xfer(lowAddr, 1'b1, 1'b1);
        `CHK({clockReleaseBit, sclOeN}, 2'b00);
        sw(1, 8'h00);
        sw(0, 8'hf4);
        addressHoldEnable <= 1'b0;
        dataHoldEnable <= 1'b1;
        xfer(8'($random(seed)), 1'b1, 1'b1);
        `CHK({clockReleaseBit, sclOeN}, 2'b00);
        sw(1, 8'h00);
        dataHoldEnable <= 1'b0;
        drainOn <= 1'b0;
        // fill without draining; the next byte must stall the master
        repeat (16) xfer(8'($random(seed)), 1'b1, 1'b1);
        `CHK(bufferFullFlag, 1'b1);
        fork
            xfer(8'ha5, 1'b1, 1'b1);
            begin
                repeat (300) @(posedge clk);
                `CHK(sclOeN, 1'b0);
                drainOn <= 1'b1;
            end
        join
        repeat (80) @(posedge clk);
        `CHK({q.size() == 0, bufferFullFlag}, 2'b10);
        u_master.stop_cond();
        `CHK(stopSeen, 1'b1);
        close_out();
    end
endmodule : test_i2c_slave_ten_bit_rx

// ---- verilog/i2c_rx_consts.svh ----
`ifndef I2C_RX_CONSTS_SVH
`define I2C_RX_CONSTS_SVH

// receive fifo shape
`define RX_FIFO_WIDTH 8
`define RX_FIFO_DEPTH 16

// ten-bit address high byte prefix, bits 7..3
`define TEN_BIT_PREFIX 5'h1e

// bit counter values within one byte frame
`define LAST_DATA_BIT 4'h7
`define ACK_PENDING_CNT 4'h8
`define ACK_BIT_CNT 4'h9

// reset values
`define CLOCK_RELEASE_RESET 1'b1
`define SLAVE_ADDRESS_RESET 8'hf0
`define PIN_SYNC_RESET 3'h6

`endif

// ---- verilog/i2c_rx_pkg.sv ----
package i2c_rx_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HIGH_ADDR,
        ST_LOW_ADDR,
        ST_DATA,
        ST_IGNORE
    } rx_state_t;

endpackage : i2c_rx_pkg

// ---- verilog/i2c_slave_ten_bit_rx.sv ----
// Notes on behaviour
// RULE_01 - start sets start flag; irq flag too when start interrupt enabled
// RULE_02 - master sends high byte with write bit, then low byte
// RULE_03 - matching high byte sets the address refresh flag
// RULE_04 - matching high byte is acked, then irq flag is set
// RULE_05 - reading the receive buffer clears the buffer full flag; here only the read that takes the last queued fifo byte clears it
// RULE_06 - after high match hold scl low until address register written
// RULE_07 - address register writes refused during the ack sequence
// RULE_08 - matching low byte sets refresh flag, is acked, sets irq flag
// RULE_09 - low mismatch sets irq and refresh flags, no buffer, release untouched
// RULE_10 - software reloads the high address after the low byte
// RULE_11 - each data byte acked on ninth scl pulse, then irq flag set
// RULE_12 - with stretch enable, release bit cleared after data byte, scl held
// RULE_13 - software setting the release bit lets scl go
// RULE_14 - data byte sequence repeats until a stop
// RULE_15 - address and data hold enables clear release bit and hold scl
// RULE_16 - address register write clears the refresh flag
// RULE_17 - after a mismatch bytes are ignored and not acked until start
`timescale 1ns/1ns
`include "i2c_rx_consts.svh"

module i2c_slave_ten_bit_rx (
    // system clock and reset
    input wire logic clk,
    input wire logic reset,
    // link clock, the scl wire itself
    input wire logic sclClk,
    // i2c pins
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOeN,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // software control
    input wire logic [7:0] slaveAddressData,
    input wire logic slaveAddressWrite,
    input wire logic stretchEnable,
    input wire logic addressHoldEnable,
    input wire logic dataHoldEnable,
    input wire logic startIrqEnable,
    input wire logic clockReleaseSet,
    input wire logic irqFlagClear,
    input wire logic bufferRead,
    // software status
    output logic [7:0] receiveBuffer,
    output logic bufferFullFlag,
    output logic serialPortIrqFlag,
    output logic addressRefreshFlag,
    output logic startSeen,
    output logic stopSeen,
    output logic clockReleaseBit,
    output logic [7:0] slaveAddressReg
);

    // link domain: shift on every scl rise, toggle marks the rise
    logic [7:0] linkShift, next_linkShift;
    logic linkToggle, next_linkToggle;

    always_comb begin
        next_linkShift = {linkShift[6:0], sdaIn};
        next_linkToggle = ~linkToggle;
    end

    // scl stands still in reset, so this domain resets without its clock
    always_ff @(posedge sclClk or posedge reset) begin
        if (reset) begin
            linkShift <= 8'h00;
            linkToggle <= 1'b0;
        end else begin
            linkShift <= next_linkShift;
            linkToggle <= next_linkToggle;
        end
    end

    // pins and the rise toggle into the system domain
    logic sclS, sdaS, toggleS;

    sync_two_ff #(
        .WIDTH(3),
        .RESET_VALUE(`PIN_SYNC_RESET)
    ) pinSync (
        .clk(clk),
        .reset(reset),
        .din({sclIn, sdaIn, linkToggle}),
        .dout({sclS, sdaS, toggleS})
    );

    i2c_rx_pkg::rx_state_t state, next_state;
    logic [3:0] bitCount, next_bitCount;
    logic prevScl, prevSda, prevToggle;
    logic accept, next_accept;
    logic ackDrive, next_ackDrive;
    logic pushWanted, next_pushWanted;
    logic [7:0] pushData, next_pushData;
    logic addrHold, next_addrHold;
    logic next_clockRelease, next_irqFlag, next_addrRefresh;
    logic next_startSeen, next_stopSeen;
    logic [7:0] next_slaveAddress;
    logic fifoInReady;
    logic riseEvt, fallEvt, startEvt, stopEvt, byteEnd, ackEnd;
    logic addrWriteOk, highMatch, lowMatch, sclHold;

    // linkShift is read only after its toggle crossed; it then stands for a whole scl period
    assign riseEvt = toggleS != prevToggle;
    assign fallEvt = prevScl && !sclS;
    assign startEvt = prevScl && sclS && prevSda && !sdaS;
    assign stopEvt = prevScl && sclS && !prevSda && sdaS;
    assign byteEnd = riseEvt && bitCount == `LAST_DATA_BIT;
    assign ackEnd = fallEvt && bitCount == `ACK_BIT_CNT;
    assign addrWriteOk = slaveAddressWrite && bitCount < `ACK_PENDING_CNT; // RULE_07
    assign highMatch = linkShift[7:3] == `TEN_BIT_PREFIX && linkShift[7:1] == slaveAddressReg[7:1]
        && !linkShift[0]; // RULE_02
    assign lowMatch = linkShift == slaveAddressReg;

    always_comb begin
        next_state = state;
        next_bitCount = bitCount;
        next_accept = accept;
        next_ackDrive = ackDrive;
        next_pushWanted = pushWanted;
        next_pushData = pushData;
        next_addrHold = addrHold;
        next_clockRelease = clockReleaseBit;
        next_irqFlag = serialPortIrqFlag;
        next_addrRefresh = addressRefreshFlag;
        next_startSeen = startSeen;
        next_stopSeen = stopSeen;
        next_slaveAddress = slaveAddressReg;
        // clears first, so a set in the same cycle wins
        if (irqFlagClear) begin
            next_irqFlag = 1'b0;
        end
        if (pushWanted && fifoInReady) begin
            next_pushWanted = 1'b0;
        end
        if (addrWriteOk) begin
            next_slaveAddress = slaveAddressData;
            next_addrHold = 1'b0; // RULE_06
            next_addrRefresh = 1'b0; // RULE_16
        end
        if (riseEvt && bitCount < `ACK_BIT_CNT) begin
            next_bitCount = bitCount + 4'h1;
        end
        if (byteEnd) begin
            case (state)
                i2c_rx_pkg::ST_HIGH_ADDR: begin
                    if (highMatch) begin
                        next_addrRefresh = 1'b1; // RULE_03
                        next_accept = 1'b1;
                        next_pushWanted = 1'b1;
                        next_pushData = linkShift;
                    end else begin
                        next_state = i2c_rx_pkg::ST_IGNORE; // RULE_17
                    end
                end
                i2c_rx_pkg::ST_LOW_ADDR: begin
                    next_addrRefresh = 1'b1; // RULE_08
                    if (lowMatch) begin
                        next_accept = 1'b1; // RULE_08
                        next_pushWanted = 1'b1;
                        next_pushData = linkShift;
                    end else begin
                        // software must reload the high address; nothing more until a start
                        next_irqFlag = 1'b1; // RULE_09
                        next_state = i2c_rx_pkg::ST_IGNORE; // RULE_10
                    end
                end
                i2c_rx_pkg::ST_DATA: begin
                    next_accept = 1'b1;
                    next_pushWanted = 1'b1;
                    next_pushData = linkShift;
                end
                default: begin
                end
            endcase
        end
        if (fallEvt && bitCount == `ACK_PENDING_CNT && accept) begin
            next_ackDrive = 1'b1; // RULE_04 RULE_11
        end
        if (ackEnd) begin
            next_ackDrive = 1'b0;
            next_bitCount = 4'h0;
            next_accept = 1'b0;
            if (accept) begin
                next_irqFlag = 1'b1; // RULE_04 RULE_08 RULE_11
                case (state)
                    i2c_rx_pkg::ST_HIGH_ADDR: begin
                        next_addrHold = 1'b1; // RULE_06
                        next_state = i2c_rx_pkg::ST_LOW_ADDR;
                    end
                    i2c_rx_pkg::ST_LOW_ADDR: begin
                        next_state = i2c_rx_pkg::ST_DATA;
                        if (addressHoldEnable) begin
                            next_clockRelease = 1'b0; // RULE_15
                        end
                    end
                    i2c_rx_pkg::ST_DATA: begin
                        // stay here for the next byte, until stop
                        if (stretchEnable || dataHoldEnable) begin
                            next_clockRelease = 1'b0; // RULE_12 RULE_14 RULE_15
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (clockReleaseSet) begin
            next_clockRelease = 1'b1; // RULE_13
        end
        if (startEvt) begin
            next_state = i2c_rx_pkg::ST_HIGH_ADDR;
            next_bitCount = 4'h0;
            next_accept = 1'b0;
            next_ackDrive = 1'b0;
            next_startSeen = 1'b1; // RULE_01
            next_stopSeen = 1'b0;
            if (startIrqEnable) begin
                next_irqFlag = 1'b1; // RULE_01
            end
        end else if (stopEvt) begin
            next_state = i2c_rx_pkg::ST_IDLE; // RULE_14
            next_bitCount = 4'h0;
            next_accept = 1'b0;
            next_ackDrive = 1'b0;
            next_startSeen = 1'b0;
            next_stopSeen = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= i2c_rx_pkg::ST_IDLE;
            bitCount <= 4'h0;
            prevScl <= 1'b1;
            prevSda <= 1'b1;
            prevToggle <= 1'b0;
            accept <= 1'b0;
            ackDrive <= 1'b0;
            pushWanted <= 1'b0;
            pushData <= 8'h00;
            addrHold <= 1'b0;
            clockReleaseBit <= `CLOCK_RELEASE_RESET;
            serialPortIrqFlag <= 1'b0;
            addressRefreshFlag <= 1'b0;
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
            slaveAddressReg <= `SLAVE_ADDRESS_RESET;
        end else begin
            state <= next_state;
            bitCount <= next_bitCount;
            prevScl <= sclS;
            prevSda <= sdaS;
            prevToggle <= toggleS;
            accept <= next_accept;
            ackDrive <= next_ackDrive;
            pushWanted <= next_pushWanted;
            pushData <= next_pushData;
            addrHold <= next_addrHold;
            clockReleaseBit <= next_clockRelease;
            serialPortIrqFlag <= next_irqFlag;
            addressRefreshFlag <= next_addrRefresh;
            startSeen <= next_startSeen;
            stopSeen <= next_stopSeen;
            slaveAddressReg <= next_slaveAddress;
        end
    end

    // a full fifo stalls the master inside the ack low phase
    assign sclHold = addrHold || !clockReleaseBit || (ackDrive && pushWanted && !fifoInReady); // RULE_06 RULE_12
    assign sclOut = 1'b0;
    assign sclOeN = !sclHold;
    assign sdaOut = 1'b0;
    assign sdaOeN = !ackDrive; // RULE_17

    rx_fifo #(
        .WIDTH(`RX_FIFO_WIDTH),
        .DEPTH(`RX_FIFO_DEPTH)
    ) rxFifo (
        .clk(clk),
        .reset(reset),
        .inValid(pushWanted),
        .inData(pushData),
        .inReady(fifoInReady),
        .outValid(bufferFullFlag),
        .outData(receiveBuffer),
        .outReady(bufferRead) // RULE_05
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_START_FLAGS: assert property (startEvt && startIrqEnable |=> startSeen && serialPortIrqFlag) // RULE_01
        else $error("start did not raise start and irq flags");
    AST_HIGH_REFRESH: assert property (byteEnd && state == i2c_rx_pkg::ST_HIGH_ADDR && highMatch // RULE_03
        && !startEvt |=> addressRefreshFlag && accept)
        else $error("high match did not set refresh flag");
    AST_ACK_DRIVEN: assert property (fallEvt && bitCount == `ACK_PENDING_CNT && accept && !startEvt // RULE_04
        && !stopEvt |=> !sdaOeN)
        else $error("accepted byte not acked");
    AST_ADDR_HOLD: assert property (addrHold && !addrWriteOk |=> addrHold && !sclOeN) // RULE_06
        else $error("scl released before address reload");
    AST_WRITE_GUARD: assert property (slaveAddressWrite && bitCount >= `ACK_PENDING_CNT // RULE_07
        |=> $stable(slaveAddressReg))
        else $error("address written during ack");
    AST_LOW_MISS: assert property (byteEnd && state == i2c_rx_pkg::ST_LOW_ADDR && !lowMatch && !startEvt // RULE_09
        && !stopEvt && !clockReleaseSet |=> serialPortIrqFlag && addressRefreshFlag && !pushWanted
        && $stable(clockReleaseBit))
        else $error("low mismatch flags wrong");
    AST_DATA_IRQ: assert property (ackEnd && accept && state == i2c_rx_pkg::ST_DATA && !startEvt && !stopEvt // RULE_11
        |=> serialPortIrqFlag ##1 serialPortIrqFlag || $past(irqFlagClear))
        else $error("data byte did not set irq");
    AST_STRETCH: assert property (ackEnd && accept && state == i2c_rx_pkg::ST_DATA && stretchEnable // RULE_12
        && !clockReleaseSet |=> !clockReleaseBit && !sclOeN)
        else $error("stretch did not hold scl");
    AST_RELEASE: assert property (clockReleaseSet && !ackEnd |=> clockReleaseBit) // RULE_13
        else $error("release bit not set");
    AST_REFRESH_CLEAR: assert property (addrWriteOk && !byteEnd |=> !addressRefreshFlag && !addrHold) // RULE_16
        else $error("address write left refresh flag");
    AST_IGNORE_NO_ACK: assert property (state == i2c_rx_pkg::ST_IGNORE && !startEvt |=> sdaOeN [*2]) // RULE_17
        else $error("ignored byte acked");

    COV_HIGH_MATCH: cover property (byteEnd && state == i2c_rx_pkg::ST_HIGH_ADDR && highMatch);
    COV_LOW_MATCH: cover property (ackEnd && accept && state == i2c_rx_pkg::ST_LOW_ADDR);
    COV_DATA_STRETCH: cover property (ackEnd && accept && state == i2c_rx_pkg::ST_DATA && stretchEnable);
    COV_FIFO_STALL: cover property (ackDrive && pushWanted && !fifoInReady);

endmodule : i2c_slave_ten_bit_rx

// ---- verilog/rx_fifo.sv ----
`timescale 1ns/1ns

module rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic [WIDTH-1:0] next_outData;
    logic push, pop;

    assign inReady = count != (AW+1)'(DEPTH);
    assign outValid = count != '0;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        // head word registered; bypass when the head is being written now
        next_outData = (push && wrPtr == next_rdPtr) ? inData : mem[next_rdPtr];
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            outData <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            outData <= next_outData;
        end
    end

    AST_LAST_READ_EMPTIES: assert property (@(posedge clk) disable iff (reset) // RULE_05
        pop && !push && count == 1 |=> !outValid)
        else $error("reading the last byte did not clear the full flag");

    AST_FULL_REFUSES: assert property (@(posedge clk) disable iff (reset)
        count == (AW+1)'(DEPTH) && !pop |=> !inReady && count == (AW+1)'(DEPTH))
        else $error("full fifo took a word");

endmodule : rx_fifo

// ---- verilog/sync_two_ff.sv ----
`timescale 1ns/1ns

module sync_two_ff #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // stage1 feeds dout and nothing else
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1 <= RESET_VALUE;
            dout <= RESET_VALUE;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule : sync_two_ff
